// >>> hw/pad_input_pkg.sv
// constants, field layout and types for the pad input register path
package pad_input_pkg;

    // ------------------------------------------------------------------
    // register port geometry
    // ------------------------------------------------------------------
    localparam int          ADDR_W      = 4;      // register address width
    localparam int          DATA_W      = 32;     // register data width
    localparam logic [3:0]  CFG_OFS     = 4'h0;   // configuration word
    localparam logic [3:0]  STAT_OFS    = 4'h4;   // status word

    // ------------------------------------------------------------------
    // configuration word fields (bit positions)
    // ------------------------------------------------------------------
    localparam int CFG_PATH_A_REG   = 0;   // path a carries stored value
    localparam int CFG_PATH_B_REG   = 1;   // path b carries stored value
    localparam int CFG_LATCH_MODE   = 2;   // 1: level latch, 0: edge flop
    localparam int CFG_CLK_INV      = 3;   // invert element clock
    localparam int CFG_CE_USE_IN    = 4;   // enable wired to input element
    localparam int CFG_CE_USE_OUT   = 5;   // enable wired to output element
    localparam int CFG_INIT_SET     = 6;   // 1: set value, 0: reset value
    localparam int CFG_EXT_VARIANT  = 7;   // 1: two-tap delay cell
    localparam int CFG_PARTIAL_DLY  = 8;   // partial delay option
    localparam int CFG_BYPASS_DLY   = 9;   // bypass delay option
    localparam int CFG_USED_W       = 10;  // implemented config bits

    localparam logic [31:0] CFG_RST = 32'h0000_0000; // reset value, flop, full delay

    // ------------------------------------------------------------------
    // status word fields (bit positions)
    // ------------------------------------------------------------------
    localparam int STAT_Q           = 0;   // stored value
    localparam int STAT_EFF_CLK     = 1;   // element clock after inversion
    localparam int STAT_CE_EFF      = 2;   // enable seen by input element
    localparam int STAT_TAP_LO      = 3;   // resolved delay tap, 2 bits
    localparam int STAT_GSR         = 5;   // global set/reset level

    // ------------------------------------------------------------------
    // delay tap choice
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        TAP_FULL,
        TAP_PARTIAL,
        TAP_NONE
    } delay_tap_t;

endpackage : pad_input_pkg

// >>> hw/pad_input_register_path.sv
// input side of a configurable i/o cell: pad to two inward paths
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps

// Functional notes
// RULE_01: each path selects direct or stored value
// RULE_02: element is flip-flop or level latch
// RULE_03: flop captures rising edge, inversion selectable
// RULE_04: latch transparent while clock high, invertible
// RULE_05: one enable shared, per element use
// RULE_06: enable active high, unconnected means enabled
// RULE_07: no inversion of the shared enable
// RULE_08: set/reset forces configured value, reset default
// RULE_09: small cell: one tap, inserted by default
// RULE_10: extended cell: full, partial or none
// RULE_11: no option given means maximum delay
// RULE_12: delay is a static tap selection
module pad_input_register_path
    import pad_input_pkg::*;
#(
    parameter int ADDR_WIDTH = ADDR_W      // register address width
) (
    input  wire logic                  sys_clk_i,              // system clock
    input  wire logic                  reset_n_i,              // async reset, low
    input  wire logic                  pad_i,                  // pad level
    input  wire logic                  elem_clk_i,             // element clock
    input  wire logic                  storage_clock_enable_i, // shared enable
    input  wire logic                  global_set_reset_i,     // global set/reset
    input  wire logic [ADDR_WIDTH-1:0] reg_addr_i,             // register address
    input  wire logic [DATA_W-1:0]     reg_wdata_i,            // write data
    input  wire logic                  reg_wr_i,               // write strobe
    input  wire logic                  reg_rd_i,               // read strobe
    output logic      [DATA_W-1:0]     reg_rdata_o,            // read data
    output logic                       inward_path_a_o,        // first inward path
    output logic                       inward_path_b_o,        // second inward path
    output logic                       out_ce_gate_o,          // enable to out element
    output logic      [1:0]            delay_tap_o             // resolved delay tap
);

    // ------------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------------
    if (ADDR_WIDTH < 3 || ADDR_WIDTH > 16) begin : g_bad_addr
        $error("address width must lie between 3 and 16");
    end

    // the configuration bits must fit inside one data word
    if (CFG_USED_W > DATA_W) begin : g_bad_cfg
        $error("configuration bits do not fit the data word");
    end

    // ------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------
    // pick the delay tap from the variant and the two options
    // one decode feeds both the tap output stage and the status word
    function automatic delay_tap_t resolve_tap(input logic ext, input logic partial,
                                               input logic bypass);
        delay_tap_t tap;
        tap = TAP_FULL;
        if (bypass) begin
            tap = TAP_NONE;
        end else if (ext && partial) begin
            tap = TAP_PARTIAL;
        end else begin
            tap = TAP_FULL;
        end
        return tap;
    endfunction : resolve_tap

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [CFG_USED_W-1:0] cfg_ff;        // configuration bits
    logic                  q_ff;          // storage element value
    logic                  eff_clk_ff;    // last effective clock level
    logic                  path_a_ff;     // path a output stage
    logic                  path_b_ff;     // path b output stage
    logic                  ce_out_ff;     // enable to output element
    logic [1:0]            tap_ff;        // resolved tap output stage
    logic [DATA_W-1:0]     rdata_ff;      // read data stage

    // ------------------------------------------------------------------
    // configuration decode
    // ------------------------------------------------------------------
    wire        sel_a_reg   = cfg_ff[CFG_PATH_A_REG];   // path a stored
    wire        sel_b_reg   = cfg_ff[CFG_PATH_B_REG];   // path b stored
    wire        latch_mode  = cfg_ff[CFG_LATCH_MODE];   // latch form
    wire        clk_inv     = cfg_ff[CFG_CLK_INV];      // clock inverted
    wire        ce_use_in   = cfg_ff[CFG_CE_USE_IN];    // input uses enable
    wire        ce_use_out  = cfg_ff[CFG_CE_USE_OUT];   // output uses enable
    wire        init_set    = cfg_ff[CFG_INIT_SET];     // set instead of reset
    wire        ext_variant = cfg_ff[CFG_EXT_VARIANT];  // two-tap cell
    wire        opt_partial = cfg_ff[CFG_PARTIAL_DLY];  // partial option
    wire        opt_bypass  = cfg_ff[CFG_BYPASS_DLY];   // bypass option

    // ------------------------------------------------------------------
    // delay tap selection
    // ------------------------------------------------------------------
    // the delay is analog; every tap carries the same sampled level
    // bypass wins over partial; partial needs the extended cell
    wire        tap_full    = pad_i;                    // full delay tap
    wire        tap_partial = pad_i;                    // partial delay tap
    wire        tap_none    = pad_i;                    // undelayed tap
    delay_tap_t tap_sel;                                // chosen tap
    wire        tap_data;                               // data after delay

    assign tap_sel  = resolve_tap(ext_variant, opt_partial, opt_bypass); // [RULE_09] [RULE_10] [RULE_11]
    assign tap_data = (tap_sel == TAP_NONE)    ? tap_none :
                      (tap_sel == TAP_PARTIAL) ? tap_partial : tap_full; // [RULE_12]

    // ------------------------------------------------------------------
    // storage element
    // ------------------------------------------------------------------
    // enable taken as high when not wired in; never inverted
    wire ce_eff    = ce_use_in ? storage_clock_enable_i : 1'b1; // [RULE_06] [RULE_07]
    wire eff_clk   = elem_clk_i ^ clk_inv;                      // [RULE_03] [RULE_04]
    // edges are found against last cycle's level, so one clock change per
    // system cycle is the fastest the element follows; flipping the
    // inversion bit flips eff_clk too and can read as one edge
    wire clk_rise  = eff_clk & ~eff_clk_ff;                     // effective rising edge
    wire load      = latch_mode ? eff_clk : clk_rise;           // [RULE_02]
    wire init_val  = init_set;                                  // set or reset value
    wire nxt_q     = global_set_reset_i ? init_val :            // [RULE_08]
                     (ce_eff & load)    ? tap_data : q_ff;      // [RULE_06]

    // ------------------------------------------------------------------
    // inward paths and shared enable
    // ------------------------------------------------------------------
    wire nxt_path_a = sel_a_reg ? nxt_q : tap_data;               // [RULE_01]
    wire nxt_path_b = sel_b_reg ? nxt_q : tap_data;               // [RULE_01]
    wire nxt_ce_out = ce_use_out ? storage_clock_enable_i : 1'b1; // [RULE_05]

    // ------------------------------------------------------------------
    // register port decode
    // ------------------------------------------------------------------
    wire hit_cfg  = (reg_addr_i == ADDR_WIDTH'(CFG_OFS));   // config selected
    wire hit_stat = (reg_addr_i == ADDR_WIDTH'(STAT_OFS));  // status selected
    logic [DATA_W-1:0] stat_word;                           // live status
    logic [DATA_W-1:0] nxt_rdata;                           // read mux

    // status word assembled from live element state
    always_comb begin
        stat_word                        = '0;
        stat_word[STAT_Q]                = q_ff;
        stat_word[STAT_EFF_CLK]          = eff_clk;
        stat_word[STAT_CE_EFF]           = ce_eff;
        stat_word[STAT_TAP_LO +: 2]      = tap_sel;
        stat_word[STAT_GSR]              = global_set_reset_i;
    end

    // unmapped addresses and idle cycles read as zero
    always_comb begin
        nxt_rdata = '0;
        if (reg_rd_i && hit_cfg) begin
            nxt_rdata[CFG_USED_W-1:0] = cfg_ff;
        end else if (reg_rd_i && hit_stat) begin
            nxt_rdata = stat_word;
        end else begin
            nxt_rdata = '0;
        end
    end

    // ------------------------------------------------------------------
    // configuration register
    // ------------------------------------------------------------------
    // writes to the status or unmapped offsets fall through and are lost
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cfg_ff <= CFG_RST[CFG_USED_W-1:0];
        end else if (reg_wr_i && hit_cfg) begin
            cfg_ff <= reg_wdata_i[CFG_USED_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // element state; power-up gives the reset value
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            q_ff       <= 1'b0;       // [RULE_08]
            eff_clk_ff <= 1'b0;
        end else begin
            q_ff       <= nxt_q;
            eff_clk_ff <= eff_clk;
        end
    end

    // ------------------------------------------------------------------
    // output stages
    // ------------------------------------------------------------------
    // every top-level output leaves through one of these flops
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            path_a_ff <= 1'b0;
            path_b_ff <= 1'b0;
            ce_out_ff <= 1'b1;
            tap_ff    <= TAP_FULL;
            rdata_ff  <= '0;
        end else begin
            path_a_ff <= nxt_path_a;
            path_b_ff <= nxt_path_b;
            ce_out_ff <= nxt_ce_out;
            tap_ff    <= tap_sel;
            rdata_ff  <= nxt_rdata;
        end
    end

    assign inward_path_a_o = path_a_ff;
    assign inward_path_b_o = path_b_ff;
    assign out_ce_gate_o   = ce_out_ff;
    assign delay_tap_o     = tap_ff;
    assign reg_rdata_o     = rdata_ff;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    // path selection ties output to stored or direct value
    a_path_select: assert property ( // [RULE_01]
        1'b1 |=> inward_path_a_o == ($past(sel_a_reg) ? q_ff : $past(pad_i)))
        else $error("path a does not follow its selection");

    // flop form captures pad on effective rising edge
    a_flop_capture: assert property ( // [RULE_03]
        (!latch_mode && clk_rise && ce_eff && !global_set_reset_i)
        |=> q_ff == $past(pad_i))
        else $error("flop missed capture on rising edge");

    // flop form holds without an edge
    a_flop_hold: assert property ( // [RULE_02]
        (!latch_mode && !clk_rise && !global_set_reset_i) |=> $stable(q_ff))
        else $error("flop changed without an edge");

    // latch follows pad across two cycles while clock high
    a_latch_follow: assert property ( // [RULE_04]
        (latch_mode && eff_clk && ce_eff && !global_set_reset_i)[*2]
        |=> q_ff == $past(pad_i) && $past(q_ff) == $past(pad_i, 2))
        else $error("latch not transparent while clock high");

    // latch holds while its clock is low
    a_latch_hold: assert property ( // [RULE_04]
        (latch_mode && !eff_clk && !global_set_reset_i) |=> $stable(q_ff))
        else $error("latch changed while clock low");

    // wired enable low freezes the element in both forms
    a_enable_hold: assert property ( // [RULE_06]
        (ce_use_in && !storage_clock_enable_i && !global_set_reset_i)
        |=> $stable(q_ff))
        else $error("element changed with enable low");

    // shared enable reaches output element without inversion
    a_enable_out: assert property ( // [RULE_05]
        1'b1 |=> out_ce_gate_o == ($past(ce_use_out) ? $past(storage_clock_enable_i)
                                                     : 1'b1))
        else $error("output element enable wrong");

    // global set/reset forces configured value
    a_gsr_value: assert property ( // [RULE_08]
        global_set_reset_i |=> q_ff == $past(init_set))
        else $error("set/reset value not applied");

    // no option gives the full delay
    a_delay_default: assert property ( // [RULE_11]
        (!opt_partial && !opt_bypass) |=> delay_tap_o == TAP_FULL)
        else $error("default delay is not full");

    // small cell never reports the partial tap
    a_delay_small: assert property ( // [RULE_09]
        !ext_variant |=> delay_tap_o != TAP_PARTIAL)
        else $error("small cell reports partial delay");

    // read data stand only in the cycle after the strobe
    a_read_idle: assert property (
        !reg_rd_i |=> reg_rdata_o == '0)
        else $error("read data without a read strobe");

    // second path follows its own selection
    a_path_b_select: assert property ( // [RULE_01]
        1'b1 |=> inward_path_b_o == ($past(sel_b_reg) ? q_ff : $past(pad_i)))
        else $error("path b does not follow its selection");

    // latch form loads the pad while its clock is high
    a_latch_load: assert property ( // [RULE_04]
        (latch_mode && eff_clk && ce_eff && !global_set_reset_i) |=> q_ff == $past(pad_i))
        else $error("latch did not load while clock high");

    // wired enable high lets the element load, no inversion
    a_enable_active: assert property ( // [RULE_07]
        (ce_use_in && storage_clock_enable_i && load && !global_set_reset_i)
        |=> q_ff == $past(pad_i))
        else $error("element did not load with enable high");

    // enable not wired in behaves as asserted
    a_enable_unwired: assert property ( // [RULE_06]
        (!ce_use_in && load && !global_set_reset_i) |=> q_ff == $past(pad_i))
        else $error("unwired enable blocked a load");

    // set/reset wins over a loading edge
    a_gsr_priority: assert property ( // [RULE_08]
        (global_set_reset_i && load && ce_eff) |=> q_ff == $past(init_set))
        else $error("load beat set/reset");

    // extended cell with partial option takes the partial tap
    a_delay_partial: assert property ( // [RULE_10]
        (ext_variant && opt_partial && !opt_bypass) |=> delay_tap_o == TAP_PARTIAL)
        else $error("partial delay not selected");

    // bypass option removes the delay in either variant
    a_delay_bypass: assert property ( // [RULE_09]
        opt_bypass |=> delay_tap_o == TAP_NONE)
        else $error("bypass did not remove the delay");

    // tap choice never alters what reaches a direct path
    a_delay_static: assert property ( // [RULE_12]
        !sel_a_reg |=> inward_path_a_o == $past(pad_i))
        else $error("direct path altered by delay choice");

    // tap output moves only after the configuration moves
    a_tap_hold: assert property ( // [RULE_12]
        $stable(cfg_ff) |=> $stable(delay_tap_o))
        else $error("delay tap changed without a new configuration");

    // ------------------------------------------------------------------
    // register port checks
    // ------------------------------------------------------------------
    // configuration write lands at the strobe edge
    a_cfg_write: assert property (
        (reg_wr_i && hit_cfg) |=> cfg_ff == $past(reg_wdata_i[CFG_USED_W-1:0]))
        else $error("configuration write lost");

    // other cycles leave the configuration alone
    a_cfg_keep: assert property (
        !(reg_wr_i && hit_cfg) |=> $stable(cfg_ff))
        else $error("configuration changed without a write");

    // configuration read returns stored bits, rest zero
    a_read_cfg: assert property (
        (reg_rd_i && hit_cfg) |=> reg_rdata_o == DATA_W'($past(cfg_ff)))
        else $error("configuration read data wrong");

    // status read returns the word of the strobe cycle
    a_read_status: assert property (
        (reg_rd_i && hit_stat) |=> reg_rdata_o == $past(stat_word))
        else $error("status read data wrong");

endmodule : pad_input_register_path

// >>> verif/pad_source_model.sv
// far-side model: pad pin and element clock seen by the cell
`timescale 1ns/10ps
module pad_source_model (
    input  wire logic sys_clk_i,  // system clock
    output logic      pad_o,      // pad level
    output logic      elem_clk_o  // element clock level
);
    // ------------------------------------------------------------------
    // drive
    // ------------------------------------------------------------------
    // pin and element clock start low
    initial begin
        pad_o      = 1'b0;
        elem_clk_o = 1'b0;
    end

    // new pad and clock levels land just after a rising edge
    task automatic put(input logic pad, input logic clk);
        @(posedge sys_clk_i);
        pad_o      <= pad;
        elem_clk_o <= clk;
    endtask : put
endmodule : pad_source_model

// >>> verif/pad_input_register_path_tb.sv
// self-checking bench for the pad input register path
`timescale 1ns/10ps
module pad_input_register_path_tb;
    import pad_input_pkg::*;
    // ------------------------------------------------------------------
    // signals and config patterns
    // ------------------------------------------------------------------
    logic              sys_clk_i, reset_n_i, pad, eclk, ce, global_set_reset, wr, rd;
    logic [3:0]        addr;
    logic [31:0]       wdata, rdata, rv;
    logic              path_a, path_b, out_gate;
    logic [1:0]        tap;
    int                failures, num_checks;
    localparam logic [31:0] PA = 32'h1 << CFG_PATH_A_REG;   // path a stored
    localparam logic [31:0] LT = 32'h1 << CFG_LATCH_MODE;   // latch form
    localparam logic [31:0] CI = 32'h1 << CFG_CLK_INV;      // clock invert
    localparam logic [31:0] EI = 32'h1 << CFG_CE_USE_IN;    // enable on input
    localparam logic [31:0] EO = 32'h1 << CFG_CE_USE_OUT;   // enable on output
    localparam logic [31:0] IS = 32'h1 << CFG_INIT_SET;     // set value

    pad_source_model src_i (.sys_clk_i(sys_clk_i), .pad_o(pad), .elem_clk_o(eclk));
    pad_input_register_path pad_input_register_path_i (
        .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .pad_i(pad), .elem_clk_i(eclk),
        .storage_clock_enable_i(ce), .global_set_reset_i(global_set_reset), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .inward_path_a_o(path_a), .inward_path_b_o(path_b), .out_ce_gate_o(out_gate),
        .delay_tap_o(tap));

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // one-cycle write strobe
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge sys_clk_i);
        wr <= 1'b0;
    endtask : wr_reg
    // one-cycle read strobe, data taken in the following cycle only
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk_i);
        addr <= a;
        rd   <= 1'b1;
        @(posedge sys_clk_i);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    // new pad/clock levels, then settle past the sampling edge
    task automatic step(input logic p, input logic c);
        src_i.put(p, c);
        @(posedge sys_clk_i);
        #1;
    endtask : step
    // enable level change at a rising edge
    task automatic set_ce(input logic v);
        @(posedge sys_clk_i);
        ce <= v;
    endtask : set_ce

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    // power-up values and an unmapped read
    task automatic t_reset();
        rd_reg(CFG_OFS, rv);
        check(rv, 32'h0);
        check(32'(path_a), 32'h0);
        check(32'(out_gate), 32'h1);
        check(32'(tap), 32'(TAP_FULL));
        rd_reg(4'h8, rv);
        check(rv, 32'h0);
    endtask : t_reset
    // direct paths, then edge flop with and without clock inversion
    task automatic t_flop();
        step(1'b1, 1'b0);
        check(32'({path_a, path_b}), 32'h3);
        wr_reg(CFG_OFS, PA);
        step(1'b0, 1'b0);
        step(1'b1, 1'b1);
        check(32'(path_a), 32'h1);
        step(1'b0, 1'b1);
        check(32'({path_a, path_b}), 32'h2);
        step(1'b0, 1'b0);
        step(1'b0, 1'b1);
        check(32'(path_a), 32'h0);
        wr_reg(CFG_OFS, PA | CI);
        step(1'b1, 1'b0);
        check(32'(path_a), 32'h1);
        step(1'b0, 1'b1);
        check(32'(path_a), 32'h1);
    endtask : t_flop
    // level latch, transparent high, then transparent low
    task automatic t_latch();
        wr_reg(CFG_OFS, PA | LT);
        step(1'b0, 1'b1);
        check(32'(path_a), 32'h0);
        step(1'b1, 1'b1);
        check(32'(path_a), 32'h1);
        step(1'b0, 1'b0);
        check(32'(path_a), 32'h1);
        wr_reg(CFG_OFS, PA | LT | CI);
        step(1'b0, 1'b0);
        check(32'(path_a), 32'h0);
        step(1'b1, 1'b1);
        check(32'(path_a), 32'h0);
    endtask : t_latch
    // shared enable: freezes both forms, per-element use, active high
    task automatic t_enable();
        // enable low first: leaving the inverted latch reads as an edge
        set_ce(1'b0);
        wr_reg(CFG_OFS, PA | EI);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
        check(32'(path_a), 32'h0);
        check(32'(out_gate), 32'h1);
        wr_reg(CFG_OFS, PA | EI | LT);
        step(1'b1, 1'b1);
        check(32'(path_a), 32'h0);
        wr_reg(CFG_OFS, PA | EO | LT);
        step(1'b1, 1'b1);
        check(32'({path_a, out_gate}), 32'h2);
        set_ce(1'b1);
        step(1'b0, 1'b1);
        check(32'({path_a, out_gate}), 32'h1);
    endtask : t_enable
    // set/reset forces the chosen value with enable low
    task automatic t_gsr();
        wr_reg(CFG_OFS, PA | EI | IS);
        set_ce(1'b0);
        @(posedge sys_clk_i);
        global_set_reset <= 1'b1;
        @(posedge sys_clk_i);
        global_set_reset <= 1'b0;
        #1 check(32'(path_a), 32'h1);
        wr_reg(CFG_OFS, PA | EI);
        @(posedge sys_clk_i);
        global_set_reset <= 1'b1;
        @(posedge sys_clk_i);
        global_set_reset <= 1'b0;
        #1 check(32'(path_a), 32'h0);
        set_ce(1'b1);
    endtask : t_gsr
    // every variant/option combination of the delay choice
    task automatic t_delay();
        logic [2:0]  o;
        logic [1:0]  e;
        for (int i = 0; i < 8; i++) begin
            o = 3'(i);
            e = o[2] ? 2'(TAP_NONE) : ((o[0] && o[1]) ? 2'(TAP_PARTIAL) : 2'(TAP_FULL));
            wr_reg(CFG_OFS, {22'h0, o[2], o[1], o[0], 7'h0});
            step(o[1], 1'b0);
            check(32'(tap), 32'(e));
            check(32'(path_a), 32'(o[1]));
            rd_reg(STAT_OFS, rv);
            check(32'(rv[STAT_TAP_LO+:2]), 32'(e));
        end
    endtask : t_delay

    // ------------------------------------------------------------------
    // clock, reset, sequence and verdict
    // ------------------------------------------------------------------
    task automatic final_report();
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    initial begin
        sys_clk_i = 1'b0;
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end
    // watchdog, far beyond the roughly 120 cycles the run needs
    initial begin
        #100000;
        failures++;
        final_report();
    end
    initial begin
        {reset_n_i, ce, global_set_reset, wr, rd, addr, wdata} = '0;
        ce = 1'b1;
        failures = 0;
        num_checks = 0;
        repeat (5) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        t_reset();
        t_flop();
        t_latch();
        t_enable();
        t_gsr();
        t_delay();
        final_report();
    end
endmodule : pad_input_register_path_tb
